// >>> rtl/acs_pkg.sv
package acs_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] DELAY_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] SINGLE_MASK_OFFSET = 8'h0c;
  localparam logic [7:0] REPEAT_MASK_OFFSET = 8'h10;
  // Control field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SINGLE_BIT = 1;
  localparam int CTRL_REPEAT_BIT = 2;
  localparam int CTRL_PWR_GATE_DIS_BIT = 3;
  localparam int CTRL_BUSY_BIT = 8;
  localparam int CTRL_CORE_ON_BIT = 9;
  // Delay field positions
  localparam int DELAY_START_LSB = 0;
  localparam int DELAY_REPEAT_LSB = 16;
  // Reset values
  localparam logic [31:0] DELAY_RESET = 32'h0000_0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  // Timing: tick period and system clock rate
  localparam int TICK_PERIOD_NS = 40000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CORE_RESET_CYCLES = 1;
  // Sequencer states
  typedef enum logic [2:0] {
    ACS_IDLE, ACS_WAIT, ACS_CONVERT
  } acs_state_e;
endpackage : acs_pkg

// >>> rtl/acs_tick_if.sv
`timescale 1ns/1ps
// Timebase tick carried from divider to sequencer
interface acs_tick_if;
  logic run;
  logic tick;
  modport source (input run, output tick);
  modport sink (output run, input tick);
endinterface : acs_tick_if

// >>> rtl/acs_tick_div.sv
`timescale 1ns/1ps
module acs_tick_div #(
  parameter int CYCLES = acs_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Tick carrier
  acs_tick_if.source tk
);
  typedef struct packed {
    logic [15:0] count;
    logic tick;
  } acs_div_s;
  acs_div_s st;
  acs_div_s next_st;

  ////////////////////////////////////////////////////////////////
  // Free divider restarted while idle, so first delay step is full
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!tk.run) begin
      next_st.count = '0;
    end else if (st.count == 16'(CYCLES - 1)) begin
      next_st.count = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.count = st.count + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign tk.tick = st.tick;
endmodule : acs_tick_div

// >>> rtl/acs_sequencer.sv
`timescale 1ns/1ps
// Overview of operation
// - Power gating enabled: core off between sequences
// - Repeat bit set starts repeat-mask cycles
// - Repeat clear: finish cycle, clear timer, stop
// - Single bit starts one single-mask cycle
// - Single bit clears itself
// - Cycles start only while enable set
// - Enable rising sends core reset pulse
// - Enable clear: finish cycle, core off
// - Upper delay field spaces repeat cycles
// - Lower delay field delays first repeat
// - Single cycles ignore both delays
// - Core stays off until interval expires
// - Core enable raised after start delay
// - Repeat mask selects channels per pass
// - Single mask selects channels per single
module acs_sequencer #(
  parameter int TICK_CYCLES = acs_pkg::TICK_CYCLES,
  parameter int CHANNELS = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter core
  output logic corePowerOn,
  output logic coreEnable,
  output logic coreReset,
  output logic convStart,
  output logic [CHANNELS-1:0] convChannels,
  input wire logic convDone
);
  ////////////////////////////////////////////////////////////////
  // All state of the block except the tick divider lives in one packed struct
  // Register fields mirror what firmware wrote
  // Sequencer fields track the cycle in flight
  // Bus reply fields are registered so outputs come from flops
  // Core fields are registered for the same reason
  // Keeping it in one struct lets a single assignment clear every field on reset
  // Trade-off: a wide struct, but one place to look for every flop outside the divider
  typedef struct packed {
    logic enable;            // Block enable
    logic singleRun;         // Self-clearing single request
    logic repeatRun;         // Repeat mode
    logic powerGatingDisable;
    // Both delay fields, start in the low half
    logic [31:0] delay;
    logic [15:0] singleMask;
    logic [15:0] repeatMask;
    logic [15:0] chanDone;   // Per-channel done, write one clear
    // Sequencer state
    acs_pkg::acs_state_e state;
    logic curIsRepeat;       // Cycle in flight came from repeat mode
    logic firstRepeat;       // Next repeat cycle uses start delay
    logic [15:0] delayCount;
    // Bus reply flops
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // Core side flops
    logic corePowerOn;
    logic coreEnable;
    logic coreReset;
    logic convStart;
    logic [CHANNELS-1:0] convChannels;
  } acs_seq_s;

  acs_seq_s st;
  acs_seq_s next_st;
  // Tick carrier between divider and sequencer
  acs_tick_if tk ();
  // Write strobe at the access edge
  logic wrEn;
  // Read strobe at the setup edge
  logic rdEn;
  // Address hits one of the registers
  logic mapped;

  ////////////////////////////////////////////////////////////////
  // 40 us timebase, only runs while a delay is counting
  // Divider is held at zero outside the wait state, so the
  // first delay step is a full tick and never a stray partial one
  // Limitation: tick phase restarts on every wait, so an interval
  // is measured from the wait entry, not from a free-running grid
  // At the default rate a tick is a thousand clock cycles
  acs_tick_div #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tk(tk)
  );
  // Run only in wait: the divider is quiet the rest of the time
  assign tk.run = (st.state == acs_pkg::ACS_WAIT);

  ////////////////////////////////////////////////////////////////
  // APB decode: answer in the access cycle, zero wait states
  // Write strobe is the access phase so a write lands exactly once
  // Read is captured at setup so data stand when pready is high
  // Hazard: both strobes are plain decodes of the bus, no state
  // Unmapped offsets are answered with an error, never stalled
  // Back-to-back transfers are fine: each setup re-arms the reply
  always_comb begin
    wrEn = psel && penable && pwrite;
    rdEn = psel && !penable && !pwrite;
    mapped = (paddr == acs_pkg::CTRL_OFFSET) || (paddr == acs_pkg::DELAY_OFFSET) ||
      (paddr == acs_pkg::STATUS_OFFSET) || (paddr == acs_pkg::SINGLE_MASK_OFFSET) ||
      (paddr == acs_pkg::REPEAT_MASK_OFFSET);
  end

  ////////////////////////////////////////////////////////////////
  // Next-state logic for registers and sequencer
  // Pulses default low and are raised only on their event
  // The bus reply is one cycle after every setup cycle
  // Order below matters: hardware events, then writes, then the
  // sequencer, then core power, then read data; the status clear and
  // core power see what the earlier steps decided, the sequencer and read data use the old state
  always_comb begin
    next_st = st;
    next_st.coreReset = 1'b0;
    next_st.convStart = 1'b0;
    next_st.pready = psel && !penable;
    next_st.pslverr = psel && !penable && !mapped;

    // Hardware events first, so a set beats a same-cycle clear
    // Done bits gather the channels of the cycle that just ended
    // They stay set until firmware clears them
    if (st.state == acs_pkg::ACS_CONVERT && convDone) begin
      next_st.chanDone = st.chanDone | 16'(st.convChannels);
    end

    // Register writes, taken on the access edge
    // Control write takes all four bits at once
    // A rising enable also schedules the core reset pulse
    // A rising repeat bit marks the next wait as the start delay
    if (wrEn) begin
      case (paddr)
        acs_pkg::CTRL_OFFSET: begin
          next_st.enable = pwdata[acs_pkg::CTRL_ENABLE_BIT];
          next_st.singleRun = pwdata[acs_pkg::CTRL_SINGLE_BIT];
          next_st.repeatRun = pwdata[acs_pkg::CTRL_REPEAT_BIT];
          next_st.powerGatingDisable = pwdata[acs_pkg::CTRL_PWR_GATE_DIS_BIT];
          if (pwdata[acs_pkg::CTRL_ENABLE_BIT] && !st.enable) begin
            next_st.coreReset = 1'b1;
          end
          if (pwdata[acs_pkg::CTRL_REPEAT_BIT] && !st.repeatRun) begin
            next_st.firstRepeat = 1'b1;
          end
        end
        acs_pkg::DELAY_OFFSET: begin
          // A new value applies from the next wait onward
          next_st.delay = pwdata;
        end
        acs_pkg::STATUS_OFFSET: begin
          // Write one clears, unless the same cycle sets it
          next_st.chanDone = next_st.chanDone & ~(pwdata[15:0] & ~16'(
            (st.state == acs_pkg::ACS_CONVERT && convDone) ? st.convChannels : '0));
        end
        acs_pkg::SINGLE_MASK_OFFSET: begin
          // Upper half reserved, dropped
          next_st.singleMask = pwdata[15:0];
        end
        acs_pkg::REPEAT_MASK_OFFSET: begin
          // Upper half reserved, dropped
          next_st.repeatMask = pwdata[15:0];
        end
        default: begin
          // Unmapped write dropped, flagged by pslverr
        end
      endcase
    end

    // Sequencer
    // Idle picks the next cycle: single first, then repeat
    // Wait counts the programmed delay in ticks with the core off
    // Convert holds enable and channel set until the core is done
    // Hazard: a write during convert never aborts the cycle, so
    // the result of the last cycle is always complete
    case (st.state)
      acs_pkg::ACS_IDLE: begin
        // Nothing starts while the block is disabled
        // A pending single wins over repeat so it is never starved
        if (st.enable && st.singleRun) begin
          // Single goes straight to conversion, no delay
          next_st.singleRun = 1'b0;
          next_st.curIsRepeat = 1'b0;
          next_st.convChannels = CHANNELS'(st.singleMask);
          next_st.corePowerOn = 1'b1;
          next_st.coreEnable = 1'b1;
          next_st.convStart = 1'b1;
          next_st.state = acs_pkg::ACS_CONVERT;
        end else if (st.enable && st.repeatRun) begin
          next_st.delayCount = st.firstRepeat ?
            st.delay[acs_pkg::DELAY_START_LSB +: 16] :
            st.delay[acs_pkg::DELAY_REPEAT_LSB +: 16];
          // First wait uses the start delay, later ones the interval
          next_st.firstRepeat = 1'b0;
          next_st.state = acs_pkg::ACS_WAIT;
        end
      end
      acs_pkg::ACS_WAIT: begin
        // Core held off while the delay runs
        // Clearing repeat or enable abandons the wait and the count
        // A zero count starts at once, which gives back-to-back cycles
        // The count only steps on a tick, never on a plain clock
        next_st.coreEnable = 1'b0;
        if (!st.repeatRun || !st.enable) begin
          next_st.delayCount = '0;
          next_st.state = acs_pkg::ACS_IDLE;
        end else if (st.delayCount == 16'h0000) begin
          next_st.curIsRepeat = 1'b1;
          next_st.convChannels = CHANNELS'(st.repeatMask);
          next_st.corePowerOn = 1'b1;
          next_st.coreEnable = 1'b1;
          next_st.convStart = 1'b1;
          next_st.state = acs_pkg::ACS_CONVERT;
        end else if (tk.tick) begin
          next_st.delayCount = st.delayCount - 16'h0001;
        end
      end
      acs_pkg::ACS_CONVERT: begin
        // In-flight cycle always finishes, whatever firmware writes
        // Done is only honoured here, so a stray done while idle
        // or waiting cannot end a cycle that has not begun
        if (convDone) begin
          next_st.coreEnable = 1'b0;
          next_st.state = acs_pkg::ACS_IDLE;
        end
      end
      default: begin
        // Unreachable codes fall back to idle
        next_st.state = acs_pkg::ACS_IDLE;
      end
    endcase

    // Core power: held on only when gating disabled and enabled
    // With gating active the core is off in every gap between cycles
    // Power follows the next state so it drops on the same edge as
    // the enable, and rises with the start pulse
    if (next_st.state != acs_pkg::ACS_CONVERT) begin
      next_st.corePowerOn = next_st.enable && next_st.powerGatingDisable;
    end

    // Read data, registered at setup for the access cycle
    // Reads have no side effects, not even on the done bits
    // Reserved bits read as zero
    // Busy shows a cycle in flight, core-on shows core power
    if (rdEn) begin
      case (paddr)
        acs_pkg::CTRL_OFFSET: begin
          next_st.prdata = '0;
          next_st.prdata[acs_pkg::CTRL_ENABLE_BIT] = st.enable;
          next_st.prdata[acs_pkg::CTRL_SINGLE_BIT] = st.singleRun;
          next_st.prdata[acs_pkg::CTRL_REPEAT_BIT] = st.repeatRun;
          next_st.prdata[acs_pkg::CTRL_PWR_GATE_DIS_BIT] = st.powerGatingDisable;
          next_st.prdata[acs_pkg::CTRL_BUSY_BIT] = (st.state == acs_pkg::ACS_CONVERT);
          next_st.prdata[acs_pkg::CTRL_CORE_ON_BIT] = st.corePowerOn;
        end
        acs_pkg::DELAY_OFFSET: next_st.prdata = st.delay;
        acs_pkg::STATUS_OFFSET: next_st.prdata = {16'h0000, st.chanDone};
        acs_pkg::SINGLE_MASK_OFFSET: next_st.prdata = {16'h0000, st.singleMask};
        acs_pkg::REPEAT_MASK_OFFSET: next_st.prdata = {16'h0000, st.repeatMask};
        default: next_st.prdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // State register, synchronous reset
  // Every field clears on reset, then the reset values are
  // applied by name so a change of default touches one place
  // The sequencer returns to idle with the core off
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= '0;
      st.delay <= acs_pkg::DELAY_RESET;
      st.singleMask <= acs_pkg::MASK_RESET;
      st.repeatMask <= acs_pkg::MASK_RESET;
      st.state <= acs_pkg::ACS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  // No logic between the flops and the pins, so no glitches reach
  // the core and the bus sees settled values
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign corePowerOn = st.corePowerOn;
  assign coreEnable = st.coreEnable;
  assign coreReset = st.coreReset;
  assign convStart = st.convStart;
  assign convChannels = st.convChannels;
endmodule : acs_sequencer

// >>> verification/acs_core_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Converter core stand-in: one done pulse per start, lat+1 cycles after the start is sampled
module acs_core_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Sequencer side
  input wire logic convStart,
  input wire logic [7:0] lat,
  output logic convDone
);
  logic busy; // Conversion running
  logic [7:0] cnt; // Cycles left
  // Only one done per start, never a spare one
  always @(posedge core_clk) begin
    convDone <= 1'b0;
    if (!rst_n) begin
      busy <= 1'b0;
      cnt <= 8'h00;
    end else if (convStart) begin
      busy <= 1'b1;
      cnt <= lat;
    end else if (busy && cnt == 8'h00) begin
      convDone <= 1'b1;
      busy <= 1'b0;
    end else if (busy) begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule : acs_core_model

// >>> verification/acs_seq_properties.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module acs_seq_properties #(parameter int CHANNELS = 16) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core
  input wire logic corePowerOn,
  input wire logic coreEnable,
  input wire logic coreReset,
  input wire logic convStart,
  input wire logic [CHANNELS-1:0] convChannels,
  input wire logic convDone
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic wc; // Control write at access edge
  logic enReg, repReg, pgdReg, sPend; // Shadow of control bits
  logic [15:0] sMask, rMask; // Shadow of channel masks
  assign wc = psel && penable && pwrite && pready && paddr == acs_pkg::CTRL_OFFSET;
  ////////////////////////////////////////////////////////////
  // Shadow registers, updated on the same edge as the design's
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      {enReg, repReg, pgdReg, sPend} <= 4'h0;
      sMask <= 16'h0000;
      rMask <= 16'h0000;
    end else begin
      if (wc) {pgdReg, repReg, enReg} <= {pwdata[3], pwdata[2], pwdata[0]};
      // Single only pends when enabled at once
      if (wc && pwdata[1] && pwdata[0]) sPend <= 1'b1;
      else if (convStart) sPend <= 1'b0;
      if (psel && penable && pwrite && pready && paddr == acs_pkg::SINGLE_MASK_OFFSET)
        sMask <= pwdata[15:0];
      if (psel && penable && pwrite && pready && paddr == acs_pkg::REPEAT_MASK_OFFSET)
        rMask <= pwdata[15:0];
    end
  end
  ////////////////////////////////////////////////////////////
  property p_rst_cause; $rose(enReg) |-> ##[0:2] coreReset; endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("no core reset");
  property p_rst_pulse; coreReset |=> !coreReset; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("core reset too long");
  property p_start_en; convStart |-> $past(enReg); endproperty
  a_start_en: assert property (p_start_en) else $error("start while disabled");
  property p_start_src; convStart |-> $past(sPend) || $past(repReg); endproperty
  a_start_src: assert property (p_start_src) else $error("start without request");
  property p_single_fast;
    wc && pwdata[1:0] == 2'b11 && !coreEnable && !repReg |-> ##[1:3] convStart;
  endproperty
  a_single_fast: assert property (p_single_fast) else $error("single start late");
  property p_chan; convStart |-> 16'(convChannels) == (sPend ? sMask : rMask); endproperty
  a_chan: assert property (p_chan) else $error("wrong channel set");
  property p_core_on; coreEnable |-> corePowerOn; endproperty
  a_core_on: assert property (p_core_on) else $error("enable without power");
  property p_core_rise; $rose(coreEnable) |-> convStart; endproperty
  a_core_rise: assert property (p_core_rise) else $error("enable early");
  property p_pwr_gate; (!pgdReg && !coreEnable) [*2] |-> !corePowerOn; endproperty
  a_pwr_gate: assert property (p_pwr_gate) else $error("power not gated");
  property p_done_drop; convDone && coreEnable |=> !coreEnable; endproperty
  a_done_drop: assert property (p_done_drop) else $error("enable held");
  c_single: cover property (convStart && sPend);
  c_repeat: cover property (convStart && !sPend);
  c_reset: cover property (coreReset);
endmodule : acs_seq_properties

// >>> verification/test_adc_conversion_sequencer.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin miscompares++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
////////////////////////////////////////////////////////////
module test_adc_conversion_sequencer;
  localparam int TICKS = 4; // Short tick keeps delays quick
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] ex; logic e;} acs_row_s;
  logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, lat = 8'h03;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, corePowerOn, coreEnable, coreReset, convStart, convDone, err;
  logic [15:0] convChannels;
  int miscompares = 0, totalChecks = 0, starts = 0, resets = 0, n, s0;
  acs_row_s rows [4] = '{
    '{acs_pkg::DELAY_OFFSET, 32'h0004_0003, 32'h0004_0003, 1'b0},
    '{acs_pkg::SINGLE_MASK_OFFSET, 32'hffff_00a5, 32'h0000_00a5, 1'b0},
    '{acs_pkg::REPEAT_MASK_OFFSET, 32'h0000_5a00, 32'h0000_5a00, 1'b0},
    '{8'h20, 32'h0000_1234, 32'h0, 1'b1}};
  always #20 core_clk = ~core_clk;
  // Pulse counters seen at the edge
  always @(posedge core_clk) begin
    starts += (convStart === 1'b1);
    resets += (coreReset === 1'b1);
  end
  acs_sequencer #(.TICK_CYCLES(TICKS)) dut (.core_clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .corePowerOn, .coreEnable, .coreReset,
    .convStart, .convChannels, .convDone);
  acs_core_model core (.core_clk, .rst_n, .convStart, .lat, .convDone);
  task results;
    $display("checks %0d miscompares %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // One APB transfer, held until pready is seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin `CHK("pready", 1'b1, 1'b0) results(); end
  endtask : apb
  // Bounded wait for a start pulse; n holds cycles waited
  task waitStart(input int maxc);
    for (n = 0; n < maxc; n++) begin
      @(posedge core_clk);
      if (convStart === 1'b1) break;
    end
  endtask : waitStart
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(0, acs_pkg::DELAY_OFFSET, 0); `CHK("delay rst", acs_pkg::DELAY_RESET, rd)
    apb(0, acs_pkg::CTRL_OFFSET, 0); `CHK("ctrl rst", 32'h0, rd)
    foreach (rows[i]) begin
      apb(1, rows[i].a, rows[i].d);
      apb(0, rows[i].a, 0);
      `CHK("rdata", rows[i].ex, rd)
      `CHK("slverr", rows[i].e, err)
    end
    // Single run ignores both delays
    apb(1, acs_pkg::CTRL_OFFSET, 32'h3); waitStart(6);
    `CHK("single prompt", 1'b1, convStart)
    `CHK("single chans", 16'h00a5, convChannels)
    waitStart(40); `CHK("one start", 1, starts)
    apb(0, acs_pkg::CTRL_OFFSET, 0); `CHK("single clr", 1'b0, rd[1])
    `CHK("pwr gap", 1'b0, corePowerOn)
    // Repeat: start delay 3 ticks, interval 4 ticks; tick phase restarts at each wait
    apb(1, acs_pkg::CTRL_OFFSET, 32'h5); waitStart(60);
    `CHK("first delay", 1'b1, n >= 2 * TICKS && n <= 3 * TICKS + 4)
    `CHK("rpt chans", 16'h5a00, convChannels)
    repeat (8) @(posedge core_clk);
    `CHK("gap off", 2'b00, {corePowerOn, coreEnable})
    waitStart(100); `CHK("interval", 1'b1, n >= 3 * TICKS - 8 && n <= 4 * TICKS + 8)
    // Slow core, enable and repeat dropped mid cycle
    lat <= 8'd30; waitStart(100);
    apb(1, acs_pkg::CTRL_OFFSET, 32'h0); `CHK("finish", 1'b1, coreEnable)
    s0 = starts; waitStart(120); `CHK("no rpt", s0, starts)
    `CHK("off", 1'b0, corePowerOn)
    apb(1, acs_pkg::CTRL_OFFSET, 32'h2); waitStart(20); `CHK("disabled", s0, starts)
    // Gating disabled keeps the core powered while enabled
    apb(1, acs_pkg::CTRL_OFFSET, 32'h9); repeat (3) @(posedge core_clk);
    `CHK("pwr kept", 1'b1, corePowerOn)
    apb(1, acs_pkg::CTRL_OFFSET, 32'h1); repeat (3) @(posedge core_clk);
    `CHK("pwr gated", 1'b0, corePowerOn)
    `CHK("core resets", 2, resets)
    // Mid-run reset brings core power, delay and control back to their reset values
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    `CHK("rst pwr", 1'b0, corePowerOn)
    apb(0, acs_pkg::DELAY_OFFSET, 0); `CHK("delay rst2", acs_pkg::DELAY_RESET, rd)
    apb(0, acs_pkg::CTRL_OFFSET, 0); `CHK("ctrl rst2", 32'h0, rd)
    results();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    results();
  end
endmodule : test_adc_conversion_sequencer
bind acs_sequencer acs_seq_properties #(.CHANNELS(CHANNELS)) chk (.core_clk, .rst_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .corePowerOn, .coreEnable,
  .coreReset, .convStart, .convChannels, .convDone);
